// ===== sdi_map.svh
`ifndef SDI_MAP_SVH
`define SDI_MAP_SVH

// ==========================================================================
// Register byte addresses
`define SDI_A2BCR_ADDR 32'hfec1_0008
`define SDI_A3BCR_ADDR 32'hfec1_000c
`define SDI_A2WCR_ADDR 32'hfec1_0028
`define SDI_A3WCR_ADDR 32'hfec1_002c
`define SDI_SDRAM_CONTROL_ADDR 32'hfec1_0044
`define SDI_REFRESH_TIMER_CONTROL_STATUS_ADDR 32'hfec1_0048
`define SDI_REFRESH_TIME_CONSTANT_ADDR 32'hfec1_0050
`define SDI_STAT_ADDR 32'hfec1_0060
`define SDI_MODE_WIN 20'hf_ec15
`define SDI_MODE_WIN_F 31:12
`define SDI_MODE_F 11:0

// ==========================================================================
// Reset values
`define SDI_A2BCR_RST 32'h36db_0600
`define SDI_A3BCR_RST 32'h0000_0000
`define SDI_A2WCR_RST 32'h0000_0540
`define SDI_A3WCR_RST 32'h0000_0000
`define SDI_SDRAM_CONTROL_RST 32'h0000_0000
`define SDI_REFRESH_TIMER_CONTROL_STATUS_RST 8'h00
`define SDI_REFRESH_TIME_CONSTANT_RST 8'h00

// ==========================================================================
// Field positions and codes
`define SDI_IWW_F 30:28
`define SDI_TYPE_F 15:12
`define SDI_BSZ_F 10:9
`define SDI_TYPE_SDRAM 4'h4
`define SDI_BSZ_16 2'h2
`define SDI_TRP_F 14:13
`define SDI_ACTIVATE_TO_COLUMN_F 11:10
`define SDI_CL_F 8:7
`define SDI_TRWL_F 3:2
`define SDI_TRC_F 1:0
`define SDI_REFRESH_ENABLE_B 11
`define SDI_REFRESH_KIND_B 10
`define SDI_POWER_DOWN_AFTER_ACCESS_B 9
`define SDI_BANK_ACTIVE_MODE_B 8
`define SDI_ROW_F 4:3
`define SDI_CMF_B 7
`define SDI_COMPARE_IRQ_ENABLE_B 6
`define SDI_CKS_F 5:3
`define SDI_RRC_F 2:0
`define SDI_LOW_F 7:0
`define SDI_KEY_F 31:16
`define SDI_KEY 16'ha55a
`define SDI_STAT_BUSY_B 0
`define SDI_STAT_DONE_B 1
`define SDI_INIT_REFS 4'h8
`define SDI_AP_PIN 11

// ==========================================================================
// Commands as {select_n, ras_n, cas_n, read_write_strobe_n}
`define SDI_CMD_DESEL 4'hf
`define SDI_CMD_PRECHARGE_ALL_CMD 4'h2
`define SDI_CMD_REF 4'h1
`define SDI_CMD_MRS 4'h0

`endif

// ===== sdi_pkg.sv
package sdi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRECHARGE_ALL_CMD,
    ST_PWAIT,
    ST_REF,
    ST_RWAIT,
    ST_MRS
  } sdi_state_e;
endpackage

// ===== sdi_ctrl.sv
// Function
// R01: Software programs area, wait and control registers before the mode write.
// R02: Software keeps the memory idle 200 us after power-up before initializing.
// R03: Mode-set is coded on select, row, column, strobe pins; address is the mode.
// R04: A write into the mode window starts init; data ignored, address drives pins.
// R05: Init opens with precharge-all, then idle cycles from precharge-to-activate field.
// R06: Exactly eight consecutive auto-refreshes follow the precharge-all.
// R07: Each init auto-refresh is followed by refresh-to-activate idle cycles.
// R08: Mode-set is issued last, after the eighth refresh and its idle cycles.
// R09: Write turnaround idle field sets idle cycles; code 001 means one.
// R10: Memory type field code 0100 marks the area as synchronous DRAM.
// R11: Bus width field code 10 selects a 16-bit data bus.
// R12: Precharge-to-activate code 01 gives two cycles.
// R13: Activate-to-column code 01 gives two cycles.
// R14: Area CAS latency code 01 gives latency two.
// R15: Write recovery code 10 gives two cycles.
// R16: Refresh recovery code 10 gives six cycles.
// R17: Refresh enable 1 enables refresh; refresh kind 0 selects auto-refresh.
// R18: Power-down 0 keeps memory awake; bank-active 0 means auto-precharge.
// R19: Row width code 01 selects twelve row bits.
// R20: Compare interrupt enable gates the match flag request; 0 suppresses it.
// R21: Prescale select 010 clocks the refresh counter at bus clock over 16.
// R22: Refresh timer writes need key A55A in the upper halfword.
// R23: Counter reaching the constant sets the flag, requests refresh, restarts.
`timescale 1ns/1ps
`default_nettype none
`include "sdi_map.svh"

module sdi_ctrl #(
  parameter int ADDR_W = 15
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic sdram_area_select_n,
  output logic ras_n,
  output logic cas_n,
  output logic read_write_strobe_n,
  output logic [ADDR_W-1:0] sdram_addr,
  output logic refresh_irq,
  output logic area_is_sdram,
  output logic bus_width_16,
  output logic [2:0] write_turnaround_idle,
  output logic [3:0] activate_to_column,
  output logic [3:0] area_cas_latency,
  output logic [3:0] write_recovery,
  output logic [3:0] area_row_width,
  output logic auto_precharge_en,
  output logic power_down_after_access
);

  // ========================================================================
  // Code tables
  function automatic logic [3:0] one_based(input logic [1:0] code);
    one_based = {2'b00, code} + 4'h1;
  endfunction

  function automatic logic [3:0] refresh_gap(input logic [1:0] code);
    case (code)
      2'b00: refresh_gap = 4'h3;
      2'b01: refresh_gap = 4'h4;
      2'b10: refresh_gap = 4'h6;
      default: refresh_gap = 4'h9;
    endcase
  endfunction

  // Division minus one; code 000 stops the counter
  function automatic logic [11:0] presc_mask(input logic [2:0] code);
    case (code)
      3'b001: presc_mask = 12'h003;
      3'b010: presc_mask = 12'h00f;
      3'b011: presc_mask = 12'h03f;
      3'b100: presc_mask = 12'h0ff;
      3'b101: presc_mask = 12'h3ff;
      3'b110: presc_mask = 12'h7ff;
      3'b111: presc_mask = 12'hfff;
      default: presc_mask = 12'h000;
    endcase
  endfunction

  // ========================================================================
  // Reset release
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ========================================================================
  // Declarations
  sdi_pkg::sdi_state_e state_q, state_d;
  logic [31:0] a2bcr_q, a3bcr_q, a2wcr_q, a3wcr_q, sdram_control_q;
  logic cmf_q, compare_irq_enable_q;
  logic [2:0] cks_q, rrc_q;
  logic [7:0] refresh_time_constant_q, rtcnt_q;
  logic [11:0] pre_q;
  logic rf_pend_q, init_q, done_q;
  logic [3:0] cnt_q, cnt_d, ref_cnt_q;
  logic [11:0] mode_q;
  localparam logic [7:0] refresh_timer_control_status_rst = `SDI_REFRESH_TIMER_CONTROL_STATUS_RST;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_n);

  // ========================================================================
  // Register decode
  wire key_ok = bus_wdata[`SDI_KEY_F] == `SDI_KEY;
  wire wr_a2bcr = bus_wr && bus_addr == `SDI_A2BCR_ADDR;
  wire wr_a3bcr = bus_wr && bus_addr == `SDI_A3BCR_ADDR;
  wire wr_a2wcr = bus_wr && bus_addr == `SDI_A2WCR_ADDR;
  wire wr_a3wcr = bus_wr && bus_addr == `SDI_A3WCR_ADDR;
  wire wr_sdram_control = bus_wr && bus_addr == `SDI_SDRAM_CONTROL_ADDR;
  wire wr_refresh_timer_control_status = bus_wr && bus_addr == `SDI_REFRESH_TIMER_CONTROL_STATUS_ADDR && key_ok; // R22
  wire wr_refresh_time_constant = bus_wr && bus_addr == `SDI_REFRESH_TIME_CONSTANT_ADDR && key_ok; // R22
  wire mode_wr = bus_wr && bus_addr[`SDI_MODE_WIN_F] == `SDI_MODE_WIN;
  // Settings must already be in place; the sequence reads them live
  wire start = mode_wr && state_q == sdi_pkg::ST_IDLE; // R01 R04

  wire [31:0] refresh_timer_control_status_rd = {24'h00_0000, cmf_q, compare_irq_enable_q, cks_q, rrc_q};
  wire [31:0] stat_rd = {30'h0000_0000, done_q, state_q != sdi_pkg::ST_IDLE};
  wire [31:0] rdata_d =
    !bus_rd ? bus_rdata :
    bus_addr == `SDI_A2BCR_ADDR ? a2bcr_q :
    bus_addr == `SDI_A3BCR_ADDR ? a3bcr_q :
    bus_addr == `SDI_A2WCR_ADDR ? a2wcr_q :
    bus_addr == `SDI_A3WCR_ADDR ? a3wcr_q :
    bus_addr == `SDI_SDRAM_CONTROL_ADDR ? sdram_control_q :
    bus_addr == `SDI_REFRESH_TIMER_CONTROL_STATUS_ADDR ? refresh_timer_control_status_rd :
    bus_addr == `SDI_REFRESH_TIME_CONSTANT_ADDR ? {24'h00_0000, refresh_time_constant_q} :
    bus_addr == `SDI_STAT_ADDR ? stat_rd : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      a2bcr_q <= `SDI_A2BCR_RST;
      a3bcr_q <= `SDI_A3BCR_RST;
      a2wcr_q <= `SDI_A2WCR_RST;
      a3wcr_q <= `SDI_A3WCR_RST;
      sdram_control_q <= `SDI_SDRAM_CONTROL_RST;
      bus_rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_a2bcr) a2bcr_q <= bus_wdata;
      if (wr_a3bcr) a3bcr_q <= bus_wdata;
      if (wr_a2wcr) a2wcr_q <= bus_wdata;
      if (wr_a3wcr) a3wcr_q <= bus_wdata;
      if (wr_sdram_control) sdram_control_q <= bus_wdata;
      bus_rdata <= rdata_d;
    end
  end

  // ========================================================================
  // Timing fields, shared by both areas through the area-3 word
  wire [3:0] trp_cyc = one_based(a3wcr_q[`SDI_TRP_F]); // R12
  wire [3:0] trc_cyc = refresh_gap(a3wcr_q[`SDI_TRC_F]); // R16
  wire refresh_on = sdram_control_q[`SDI_REFRESH_ENABLE_B] && !sdram_control_q[`SDI_REFRESH_KIND_B]; // R17

  // ========================================================================
  // Refresh timer
  wire [11:0] mask = presc_mask(cks_q);
  wire tick = cks_q != 3'b000 && (pre_q & mask) == mask; // R21
  wire match = tick && rtcnt_q == refresh_time_constant_q; // R23
  wire cmf_clr = wr_refresh_timer_control_status && !bus_wdata[`SDI_CMF_B];
  wire rf_take = state_d == sdi_pkg::ST_REF && !init_q && !start;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmf_q <= refresh_timer_control_status_rst[`SDI_CMF_B];
      compare_irq_enable_q <= refresh_timer_control_status_rst[`SDI_COMPARE_IRQ_ENABLE_B];
      cks_q <= refresh_timer_control_status_rst[`SDI_CKS_F];
      rrc_q <= refresh_timer_control_status_rst[`SDI_RRC_F];
      refresh_time_constant_q <= `SDI_REFRESH_TIME_CONSTANT_RST;
      rtcnt_q <= 8'h00;
      pre_q <= 12'h000;
      rf_pend_q <= 1'b0;
    end else if (ce) begin
      // A new match beats a clear in the same cycle
      cmf_q <= match || (cmf_q && !cmf_clr); // R23
      rf_pend_q <= (match && refresh_on) || (rf_pend_q && !rf_take); // R17 R23
      if (wr_refresh_timer_control_status) begin
        compare_irq_enable_q <= bus_wdata[`SDI_COMPARE_IRQ_ENABLE_B];
        cks_q <= bus_wdata[`SDI_CKS_F];
        rrc_q <= bus_wdata[`SDI_RRC_F];
      end
      if (wr_refresh_time_constant) refresh_time_constant_q <= bus_wdata[`SDI_LOW_F];
      pre_q <= (tick || cks_q == 3'b000) ? 12'h000 : pre_q + 12'h001;
      if (match) rtcnt_q <= 8'h00;
      else if (tick) rtcnt_q <= rtcnt_q + 8'h01;
    end
  end

  // ========================================================================
  // Command sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      sdi_pkg::ST_IDLE: begin
        if (start) begin
          state_d = sdi_pkg::ST_PRECHARGE_ALL_CMD; // R05
        end else if (rf_pend_q) begin
          state_d = sdi_pkg::ST_REF;
        end
      end
      sdi_pkg::ST_PRECHARGE_ALL_CMD: begin
        state_d = sdi_pkg::ST_PWAIT;
        cnt_d = trp_cyc - 4'h1; // R05 R12
      end
      sdi_pkg::ST_PWAIT: begin
        if (cnt_q == 4'h0) state_d = sdi_pkg::ST_REF;
        else cnt_d = cnt_q - 4'h1;
      end
      sdi_pkg::ST_REF: begin
        state_d = sdi_pkg::ST_RWAIT;
        cnt_d = trc_cyc - 4'h1; // R07 R16
      end
      sdi_pkg::ST_RWAIT: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (!init_q) begin
          state_d = sdi_pkg::ST_IDLE;
        end else if (ref_cnt_q == `SDI_INIT_REFS) begin
          state_d = sdi_pkg::ST_MRS; // R08
        end else begin
          state_d = sdi_pkg::ST_REF; // R06
        end
      end
      sdi_pkg::ST_MRS: state_d = sdi_pkg::ST_IDLE;
      default: state_d = sdi_pkg::ST_IDLE;
    endcase
  end

  // Pins are registered from the next state so they line up with state_q
  wire [3:0] cmd_d =
    state_d == sdi_pkg::ST_PRECHARGE_ALL_CMD ? `SDI_CMD_PRECHARGE_ALL_CMD :
    state_d == sdi_pkg::ST_REF ? `SDI_CMD_REF :
    state_d == sdi_pkg::ST_MRS ? `SDI_CMD_MRS : `SDI_CMD_DESEL; // R03
  wire [ADDR_W-1:0] precharge_all_cmd_addr = ADDR_W'(1) << `SDI_AP_PIN;
  wire [ADDR_W-1:0] addr_d =
    state_d == sdi_pkg::ST_PRECHARGE_ALL_CMD ? precharge_all_cmd_addr :
    state_d == sdi_pkg::ST_MRS ? ADDR_W'(mode_q) : '0; // R03 R04

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= sdi_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      ref_cnt_q <= 4'h0;
      init_q <= 1'b0;
      done_q <= 1'b0;
      mode_q <= 12'h000;
      {sdram_area_select_n, ras_n, cas_n, read_write_strobe_n} <= `SDI_CMD_DESEL;
      sdram_addr <= '0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      // Write data is dropped; only the address carries the mode
      if (start) begin
        mode_q <= bus_addr[`SDI_MODE_F]; // R04
        init_q <= 1'b1;
        ref_cnt_q <= 4'h0;
      end else if (init_q && state_q == sdi_pkg::ST_REF) begin
        ref_cnt_q <= ref_cnt_q + 4'h1; // R06
      end
      if (state_q == sdi_pkg::ST_MRS) begin
        init_q <= 1'b0;
        done_q <= 1'b1;
      end
      {sdram_area_select_n, ras_n, cas_n, read_write_strobe_n} <= cmd_d;
      sdram_addr <= addr_d;
    end
  end

  // ========================================================================
  // Decoded settings for the access path
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      refresh_irq <= 1'b0;
      area_is_sdram <= 1'b0;
      bus_width_16 <= 1'b0;
      write_turnaround_idle <= 3'b000;
      activate_to_column <= 4'h1;
      area_cas_latency <= 4'h1;
      write_recovery <= 4'h0;
      area_row_width <= 4'hb;
      auto_precharge_en <= 1'b1;
      power_down_after_access <= 1'b0;
    end else if (ce) begin
      refresh_irq <= cmf_q && compare_irq_enable_q; // R20
      area_is_sdram <= a3bcr_q[`SDI_TYPE_F] == `SDI_TYPE_SDRAM; // R10
      bus_width_16 <= a3bcr_q[`SDI_BSZ_F] == `SDI_BSZ_16; // R11
      write_turnaround_idle <= a3bcr_q[`SDI_IWW_F]; // R09
      activate_to_column <= one_based(a3wcr_q[`SDI_ACTIVATE_TO_COLUMN_F]); // R13
      area_cas_latency <= one_based(a3wcr_q[`SDI_CL_F]); // R14
      write_recovery <= {2'b00, a3wcr_q[`SDI_TRWL_F]}; // R15
      area_row_width <= 4'hb + {2'b00, sdram_control_q[`SDI_ROW_F]}; // R19
      auto_precharge_en <= !sdram_control_q[`SDI_BANK_ACTIVE_MODE_B]; // R18
      power_down_after_access <= sdram_control_q[`SDI_POWER_DOWN_AFTER_ACCESS_B]; // R18
    end
  end

  // ========================================================================
  // Checks
  a_mrs_pins: assert property (state_q == sdi_pkg::ST_MRS |->
    {sdram_area_select_n, ras_n, cas_n, read_write_strobe_n} == `SDI_CMD_MRS &&
    sdram_addr == ADDR_W'(mode_q)) // R03
    else $error("mode-set pins wrong");
  a_start_precharge_all_cmd: assert property (ce && start |=> state_q == sdi_pkg::ST_PRECHARGE_ALL_CMD &&
    {sdram_area_select_n, ras_n, cas_n, read_write_strobe_n} == `SDI_CMD_PRECHARGE_ALL_CMD) // R05
    else $error("init did not open with precharge-all");
  a_precharge_all_cmd_wait: assert property (ce && state_q == sdi_pkg::ST_PRECHARGE_ALL_CMD |=>
    state_q == sdi_pkg::ST_PWAIT && cnt_q == trp_cyc - 4'h1) // R12
    else $error("precharge wait not loaded");
  a_eight_refs: assert property (state_q == sdi_pkg::ST_MRS |-> ref_cnt_q == `SDI_INIT_REFS) // R06
    else $error("refresh count at mode-set not eight");
  a_ref_gap: assert property (ce && state_q == sdi_pkg::ST_REF |=>
    state_q == sdi_pkg::ST_RWAIT && cnt_q == trc_cyc - 4'h1) // R07
    else $error("refresh gap not loaded");
  a_mrs_last: assert property (ce && state_q == sdi_pkg::ST_MRS |=>
    state_q == sdi_pkg::ST_IDLE && done_q && !init_q) // R08
    else $error("mode-set not final");
  a_key_guard: assert property (ce && bus_wr && bus_addr == `SDI_REFRESH_TIMER_CONTROL_STATUS_ADDR && !key_ok |=>
    cks_q == $past(cks_q) && compare_irq_enable_q == $past(compare_irq_enable_q)) // R22
    else $error("keyless write changed timer control");
  a_irq_gate: assert property (ce && !compare_irq_enable_q |=> !refresh_irq) // R20
    else $error("interrupt not gated");
  a_match_flag: assert property (ce && match |=> cmf_q && rtcnt_q == 8'h00) // R23
    else $error("match did not set flag and restart");
  a_tick_16: assert property (ce && cks_q == 3'b010 && tick |-> pre_q == 12'h00f) // R21
    else $error("prescale not sixteen");

  c_init_done: cover property (ce && state_q == sdi_pkg::ST_MRS);
  c_auto_ref: cover property (ce && state_q == sdi_pkg::ST_REF && !init_q);
  c_flag_set: cover property (ce && match && compare_irq_enable_q);
  c_key_bad: cover property (ce && bus_wr && bus_addr == `SDI_REFRESH_TIMER_CONTROL_STATUS_ADDR && !key_ok);

endmodule

`default_nettype wire

// ===== sdi_sdram_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdi_map.svh"

// ==========================================================================
// Memory chip model: logs commands and flags protocol slips
module sdi_sdram_model #(
  parameter int TRP_IDLE = 2,
  parameter int TRC_IDLE = 6
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sdram_area_select_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic read_write_strobe_n,
  input wire logic [14:0] sdram_addr,
  output logic [7:0] precharge_all_cmd_cnt,
  output logic [7:0] ref_cnt,
  output logic [7:0] mrs_cnt,
  output logic [11:0] mode_q,
  output logic [31:0] precharge_all_cmd_at,
  output logic [31:0] mrs_at,
  output logic [31:0] ref_at,
  output logic [31:0] ref_prev,
  output logic proto_err
);
  logic [3:0] cmd;
  logic [31:0] cyc_q;
  logic [31:0] last_q;
  logic [31:0] need_q;

  assign cmd = {sdram_area_select_n, ras_n, cas_n, read_write_strobe_n};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {precharge_all_cmd_cnt, ref_cnt, mrs_cnt, mode_q} <= '0;
      {precharge_all_cmd_at, mrs_at, ref_at, ref_prev} <= '0;
      {cyc_q, last_q, need_q, proto_err} <= '0;
    end else begin
      cyc_q <= cyc_q + 32'h0000_0001;
      // A real chip gives no second chance on a short gap
      if (cmd != `SDI_CMD_DESEL) begin
        last_q <= cyc_q;
        if ((cyc_q - last_q) <= need_q) begin
          proto_err <= 1'b1;
        end
      end
      case (cmd)
        `SDI_CMD_PRECHARGE_ALL_CMD: begin
          precharge_all_cmd_cnt <= precharge_all_cmd_cnt + 8'h01;
          precharge_all_cmd_at <= cyc_q;
          need_q <= 32'(TRP_IDLE);
          if (!sdram_addr[`SDI_AP_PIN]) begin
            proto_err <= 1'b1;
          end
        end
        `SDI_CMD_REF: begin
          ref_cnt <= ref_cnt + 8'h01;
          ref_prev <= ref_at;
          ref_at <= cyc_q;
          need_q <= 32'(TRC_IDLE);
          if (precharge_all_cmd_cnt == 8'h00) begin
            proto_err <= 1'b1;
          end
        end
        `SDI_CMD_MRS: begin
          mrs_cnt <= mrs_cnt + 8'h01;
          mrs_at <= cyc_q;
          mode_q <= sdram_addr[`SDI_MODE_F];
          need_q <= '0;
          if (ref_cnt < 8'h08) begin
            proto_err <= 1'b1;
          end
        end
        `SDI_CMD_DESEL: begin
        end
        default: begin
          proto_err <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== sdi_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdi_map.svh"

module sdi_ctrl_tb;
  logic ref_clk, rst_n, ce, bus_wr, bus_rd;
  logic [31:0] bus_addr, bus_wdata, bus_rdata;
  logic sel_n, ras_n, cas_n, rws_n, irq, is_sd, bw16, apre, pdn, perr;
  logic [14:0] maddr;
  logic [2:0] tidle;
  logic [3:0] act, cl, wrec, row;
  logic [7:0] precharge_all_cmd_cnt, ref_cnt, mrs_cnt, n;
  logic [11:0] mode_q;
  logic [31:0] precharge_all_cmd_at, mrs_at, ref_at, ref_prev;
  int failures, check_count;

  sdi_ctrl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .sdram_area_select_n(sel_n), .ras_n(ras_n), .cas_n(cas_n), .read_write_strobe_n(rws_n),
    .sdram_addr(maddr), .refresh_irq(irq), .area_is_sdram(is_sd), .bus_width_16(bw16),
    .write_turnaround_idle(tidle), .activate_to_column(act), .area_cas_latency(cl),
    .write_recovery(wrec), .area_row_width(row), .auto_precharge_en(apre),
    .power_down_after_access(pdn));
  sdi_sdram_model i_mem (.ref_clk(ref_clk), .rst_n(rst_n), .sdram_area_select_n(sel_n),
    .ras_n(ras_n), .cas_n(cas_n), .read_write_strobe_n(rws_n), .sdram_addr(maddr),
    .precharge_all_cmd_cnt(precharge_all_cmd_cnt), .ref_cnt(ref_cnt), .mrs_cnt(mrs_cnt), .mode_q(mode_q),
    .precharge_all_cmd_at(precharge_all_cmd_at), .mrs_at(mrs_at), .ref_at(ref_at), .ref_prev(ref_prev), .proto_err(perr));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Bus tasks and checks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask

  // Decoded outputs lag the register by one cycle
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_cnt(input logic use_mrs, input logic [7:0] want, input int lim);
    int k;
    k = 0;
    while ((use_mrs ? mrs_cnt : ref_cnt) !== want && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    if ((use_mrs ? mrs_cnt : ref_cnt) !== want) begin
      failures++;
      $display("mismatch t=%0t wait ran out got=%h exp=%h", $time, use_mrs ? mrs_cnt : ref_cnt, want);
      final_report();
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    failures = 0;
    check_count = 0;
    {rst_n, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    ce = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Memory stays idle for its 200 us power-up settling time
    repeat (40000) @(posedge ref_clk);
    rd(32'hfec1_0008, 32'h36db_0600);
    rd(32'hfec1_0028, 32'h0000_0540);
    rd(32'hfec1_0004, 32'h0000_0000);
    wr(32'hfec1_000c, 32'h1000_4400);
    wr(32'hfec1_002c, 32'h0000_248a);
    wr(32'hfec1_0044, 32'h0000_0b09);
    settle();
    chk(32'(apre), 32'h0000_0000);
    chk(32'(pdn), 32'h0000_0001);
    wr(32'hfec1_0044, 32'h0000_0809);
    settle();
    chk(32'(is_sd), 32'h0000_0001);
    chk(32'(bw16), 32'h0000_0001);
    chk(32'(tidle), 32'h0000_0001);
    chk(32'(act), 32'h0000_0002);
    chk(32'(cl), 32'h0000_0002);
    chk(32'(wrec), 32'h0000_0002);
    chk(32'(row), 32'h0000_000c);
    chk(32'(apre), 32'h0000_0001);
    chk(32'(pdn), 32'h0000_0000);
    rd(32'hfec1_000c, 32'h1000_4400);
    rd(32'hfec1_002c, 32'h0000_248a);
    $display("test config done");

    // Mode write data is junk on purpose; a second write lands while busy
    wr(32'hfec1_5040, 32'hdead_beef);
    rd(32'hfec1_0060, 32'h0000_0001);
    wr(32'hfec1_5460, 32'h0000_0000);
    wait_cnt(1'b1, 8'h01, 200);
    settle();
    chk(32'(precharge_all_cmd_cnt), 32'h0000_0001);
    chk(32'(ref_cnt), 32'h0000_0008);
    chk(32'(mrs_cnt), 32'h0000_0001);
    chk(32'(mode_q), 32'h0000_0040);
    chk(mrs_at - precharge_all_cmd_at, 32'h0000_003b);
    chk(32'(perr), 32'h0000_0000);
    rd(32'hfec1_0060, 32'h0000_0002);
    $display("test init done");

    wr(32'hfec1_0050, 32'h0000_0003);
    rd(32'hfec1_0050, 32'h0000_0000);
    wr(32'hfec1_0050, 32'ha55a_0003);
    rd(32'hfec1_0050, 32'h0000_0003);
    // A keyed write with the enable low must leave no trace
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(32'hfec1_0050, 32'ha55a_0007);
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(32'hfec1_0050, 32'h0000_0003);
    wr(32'hfec1_0048, 32'ha55a_0050);
    wait_cnt(1'b0, 8'h0a, 400);
    settle();
    chk(32'(irq), 32'h0000_0001);
    rd(32'hfec1_0048, 32'h0000_00d0);
    // Match is taken on the tick that finds the count at the constant: four ticks of sixteen
    chk(ref_at - ref_prev, 32'h0000_0040);
    // Flag kept set so only the enable can hold the request low
    wr(32'hfec1_0048, 32'ha55a_0090);
    settle();
    chk(32'(irq), 32'h0000_0000);
    rd(32'hfec1_0048, 32'h0000_0090);
    $display("test timer done");

    wr(32'hfec1_0044, 32'h0000_0c09);
    repeat (20) @(posedge ref_clk);
    n = ref_cnt;
    repeat (300) @(posedge ref_clk);
    chk(32'(ref_cnt), 32'(n));
    wr(32'hfec1_0044, 32'h0000_0809);
    wait_cnt(1'b0, n + 8'h01, 400);
    chk(32'(perr), 32'h0000_0000);
    $display("test refresh kind done");
    final_report();
  end
endmodule
`default_nettype wire
